// [logic/dsr_status_reader.sv]
// display status read command interpreter: image mode, signal mode, self diagnostic
// assumes host strobes synchronous to i_core_clk; data lines are a tri-state bus
// Behaviour
// RQ1 - command 0Dh returns image mode byte
// RQ2 - image bit 7 shows vertical scrolling
// RQ3 - image bit 5 shows inversion on
// RQ4 - image gamma bits 2..0 read 000
// RQ5 - command 0Eh returns signal mode byte
// RQ6 - signal bit 7 shows tearing output on
// RQ7 - signal bit 6 shows tearing output mode
// RQ8 - signal bits 5..2 show hsync vsync pclk de
// RQ9 - extra parallel reads repeat the status byte
// RQ10 - serial link skips dummy, sends status only
// RQ11 - command 0Fh returns self diagnostic byte
// RQ12 - bit 7 toggles on good register load
// RQ13 - bit 6 toggles on passed function check
// RQ14 - bit 0 set when checksums differ
// RQ15 - host waits 300 ms before trusting bit 0
// RQ16 - one dummy read precedes the status read
// RQ17 - signal bit 0 shows link error
// RQ18 - diag byte zero after resets, bits 5..1 zero
`timescale 1ns/100ps
module dsr_status_reader
    import dsr_pkg::*;
#(
    parameter int DATA_W = 8
)
(
    // clock and reset
    input  wire logic              i_core_clk,
    input  wire logic              i_nrst,
    // host parallel interface
    input  wire logic              i_data_command_select,
    input  wire logic              i_read_strobe_n,
    input  wire logic              i_write_strobe_n,
    input  wire logic [DATA_W-1:0] i_data,
    output logic      [DATA_W-1:0] o_data,
    output logic      [DATA_W-1:0] o_data_oe_n,
    // link selection: high when the host talks over the serial link
    input  wire logic              i_serial_link,
    // display state feeding the status bytes
    input  wire logic              i_scroll_active,
    input  wire logic              i_inversion_on,
    input  wire logic              i_tearing_on,
    input  wire logic              i_tearing_mode,
    input  wire logic              i_hsync_on,
    input  wire logic              i_vsync_on,
    input  wire logic              i_pixel_clock_in_on,
    input  wire logic              i_pixel_data_valid_on,
    input  wire logic              i_link_error,
    // self diagnostic events
    input  wire logic              i_soft_reset,
    input  wire logic              i_reg_load_ok,
    input  wire logic              i_func_check_ok,
    input  wire logic              i_csum_mismatch,
    // status
    output logic                   o_read_busy
);
    typedef struct packed
    {
        dsr_state_e  state;
        logic [7:0]  cmd;
        logic [7:0]  diag;
        logic [7:0]  dout;
        logic        drive;
    } dsr_regs_s;

    dsr_regs_s regs;
    dsr_regs_s next_regs;
    logic      wr_rise;
    logic      rd_rise;
    logic [7:0] image_byte;
    logic [7:0] signal_byte;
    logic [7:0] status_byte;

    // strobe edges; writes latch on the rising edge of the write strobe
    dsr_strobe_edge u_wr_edge
    (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_strobe_n (i_write_strobe_n),
        .o_rise     (wr_rise)
    );

    dsr_strobe_edge u_rd_edge
    (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_strobe_n (i_read_strobe_n),
        .o_rise     (rd_rise)
    );

    // status byte assembly; reserved bits read zero
    always_comb
    begin
        image_byte                      = 8'h00;
        image_byte[IMG_SCROLL_BIT]      = i_scroll_active;     // RQ2
        image_byte[IMG_INVERT_BIT]      = i_inversion_on;      // RQ3
        image_byte[2:0]                 = IMG_GAMMA_VALUE;     // RQ4
        signal_byte                     = 8'h00;
        signal_byte[SIG_TE_ON_BIT]      = i_tearing_on;        // RQ6
        signal_byte[SIG_TE_MODE_BIT]    = i_tearing_mode;      // RQ7
        signal_byte[SIG_HSYNC_BIT]      = i_hsync_on;          // RQ8
        signal_byte[SIG_VSYNC_BIT]      = i_vsync_on;          // RQ8
        signal_byte[SIG_PCLK_BIT]       = i_pixel_clock_in_on; // RQ8
        signal_byte[SIG_DE_BIT]         = i_pixel_data_valid_on; // RQ8
        signal_byte[SIG_DSI_ERR_BIT]    = i_link_error;        // RQ17
        if (regs.cmd == CMD_READ_IMAGE_MODE)
            status_byte = image_byte;                          // RQ1
        else if (regs.cmd == CMD_READ_SIGNAL_MODE)
            status_byte = signal_byte;                         // RQ5
        else
            status_byte = regs.diag;                           // RQ11
    end

    // next state: command decode, read sequencing and diagnostic byte
    always_comb
    begin
        next_regs = regs;
        // toggles are applied together so simultaneous events are kept, except when a soft reset in the same cycle clears the byte
        if (i_reg_load_ok)
            next_regs.diag[DIAG_REGLOAD_BIT] = ~regs.diag[DIAG_REGLOAD_BIT]; // RQ12
        if (i_func_check_ok)
            next_regs.diag[DIAG_FUNC_BIT] = ~regs.diag[DIAG_FUNC_BIT];       // RQ13
        next_regs.diag[DIAG_CSUM_BIT] = i_csum_mismatch;                     // RQ14
        next_regs.diag[5:1] = 5'h00;                                         // RQ18
        if (i_soft_reset)
            next_regs.diag = DIAG_RESET_VALUE;                               // RQ18

        if (wr_rise && !i_data_command_select)
        begin
            // any command ends a read in progress
            next_regs.cmd   = i_data[7:0];
            next_regs.drive = 1'b0;
            if (i_data[7:0] == CMD_READ_IMAGE_MODE ||
                i_data[7:0] == CMD_READ_SIGNAL_MODE ||
                i_data[7:0] == CMD_READ_SELF_DIAG)
                next_regs.state = i_serial_link ? ST_DATA : ST_DUMMY;        // RQ10
            else
                next_regs.state = ST_IDLE;
        end
        else if (rd_rise && i_data_command_select)
        begin
            case (regs.state)
                ST_DUMMY:
                begin
                    // dummy phase: undefined data, here the byte left from the last read; status byte loaded as it ends
                    next_regs.dout  = status_byte;                           // RQ16
                    next_regs.state = ST_DATA;
                end
                ST_DATA:
                begin
                    next_regs.state = ST_HOLD;
                end
                ST_HOLD:
                begin
                    next_regs.state = ST_HOLD;                               // RQ9
                end
                default:
                begin
                    next_regs.state = ST_IDLE;
                end
            endcase
        end

        // refresh the driven byte whenever a status read is pending
        if (next_regs.state == ST_DATA || next_regs.state == ST_HOLD)
        begin
            next_regs.dout  = status_byte;                                   // RQ9
            next_regs.drive = 1'b1;
        end
        else if (next_regs.state == ST_DUMMY)
            next_regs.drive = 1'b1;                                          // RQ16
        else
            next_regs.drive = 1'b0;
    end

    // state register; the diag byte clears on hardware reset
    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
        begin
            regs.state <= ST_IDLE;
            regs.cmd   <= 8'h00;
            regs.diag  <= DIAG_RESET_VALUE;                                  // RQ18
            regs.dout  <= 8'h00;
            regs.drive <= 1'b0;
        end
        else
            regs <= next_regs;
    end

    // bus drive only while the host holds the read strobe low
    assign o_data      = DATA_W'(regs.dout);
    assign o_data_oe_n = {DATA_W{~(regs.drive & ~i_read_strobe_n)}};
    assign o_read_busy = (regs.state != ST_IDLE);
endmodule : dsr_status_reader

// [logic/dsr_pkg.sv]
// constants for the display status read command interpreter
// assumes a single core clock; host strobes are already synchronous to it
package dsr_pkg;
    // command codes
    localparam logic [7:0] CMD_READ_IMAGE_MODE  = 8'h0D;
    localparam logic [7:0] CMD_READ_SIGNAL_MODE = 8'h0E;
    localparam logic [7:0] CMD_READ_SELF_DIAG   = 8'h0F;
    // image mode byte fields
    localparam int IMG_SCROLL_BIT  = 7;
    localparam int IMG_INVERT_BIT  = 5;
    localparam logic [2:0] IMG_GAMMA_VALUE = 3'h0;
    // signal mode byte fields
    localparam int SIG_TE_ON_BIT   = 7;
    localparam int SIG_TE_MODE_BIT = 6;
    localparam int SIG_HSYNC_BIT   = 5;
    localparam int SIG_VSYNC_BIT   = 4;
    localparam int SIG_PCLK_BIT    = 3;
    localparam int SIG_DE_BIT      = 2;
    localparam int SIG_DSI_ERR_BIT = 0;
    // self diagnostic byte fields
    localparam int DIAG_REGLOAD_BIT = 7;
    localparam int DIAG_FUNC_BIT    = 6;
    localparam int DIAG_CSUM_BIT    = 0;
    localparam logic [7:0] DIAG_RESET_VALUE = 8'h00;
    // host timing (other party keeps it)
    localparam int CSUM_WAIT_MS = 300;
    // read sequence states
    typedef enum logic [3:0]
    {
        ST_IDLE  = 4'b0001,
        ST_DUMMY = 4'b0010,
        ST_DATA  = 4'b0100,
        ST_HOLD  = 4'b1000
    } dsr_state_e;
endpackage : dsr_pkg

// [logic/dsr_strobe_edge.sv]
// rising edge detector for an active-low host strobe
// assumes the strobe is already synchronous to the core clock
`timescale 1ns/100ps
module dsr_strobe_edge
(
    // clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_nrst,
    // strobe in, edge out
    input  wire logic i_strobe_n,
    output logic      o_rise
);
    logic prev;

    // idle level of the strobe is high, so reset to high avoids a false edge
    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
            prev <= 1'b1;
        else
            prev <= i_strobe_n;
    end

    assign o_rise = i_strobe_n & ~prev;
endmodule : dsr_strobe_edge

// [dv/dsr_host_model.sv]
// host model: command writes and read cycles on the parallel port
// assumes strobes move just after a rising edge of i_core_clk
`timescale 1ns/100ps
module dsr_host_model
(
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_data,
    input  wire logic [7:0] i_data_oe_n,
    output logic            o_dc,
    output logic            o_rd_n,
    output logic            o_wr_n,
    output logic [7:0]      o_data
);
    initial {o_dc, o_rd_n, o_wr_n, o_data} = 11'h300;
    // command byte with d/c low, write strobe low one cycle
    task cmd(input logic [7:0] c);
        @(posedge i_core_clk);
        {o_dc, o_wr_n, o_data} <= {2'b00, c};
        @(posedge i_core_clk);
        o_wr_n <= 1'b1;
        repeat (3) @(posedge i_core_clk);
    endtask : cmd
    // released bus reads inverted so stale data never matches
    task rd(output logic [7:0] v);
        @(posedge i_core_clk);
        {o_dc, o_rd_n} <= 2'b10;
        repeat (2) @(posedge i_core_clk);
        v = i_data_oe_n[0] ? ~i_data : i_data;
        o_rd_n <= 1'b1;
        repeat (2) @(posedge i_core_clk);
    endtask : rd
endmodule : dsr_host_model

// [dv/dsr_status_reader_chk.sv]
// checker on the status reader host port
// assumes strobes synchronous to the core clock
`timescale 1ns/100ps
module dsr_status_reader_chk
    import dsr_pkg::*;
#(parameter int DATA_W = 8)
(
    input logic              i_core_clk,
    input logic              i_nrst,
    input logic              i_data_command_select,
    input logic              i_read_strobe_n,
    input logic              i_write_strobe_n,
    input logic [DATA_W-1:0] i_data,
    input logic [DATA_W-1:0] o_data,
    input logic [DATA_W-1:0] o_data_oe_n,
    input logic              i_serial_link,
    input logic              i_scroll_active,
    input logic              i_inversion_on,
    input logic              i_tearing_on,
    input logic              i_tearing_mode,
    input logic              i_hsync_on,
    input logic              i_vsync_on,
    input logic              i_pixel_clock_in_on,
    input logic              i_pixel_data_valid_on,
    input logic              i_link_error,
    input logic              i_csum_mismatch,
    input logic              o_read_busy
);
    logic [7:0] cq;
    logic [1:0] rc;
    logic wq, rq, ce, kc, ok, ph;
    // command edge, known read command, status phase past the dummy
    assign ce = i_write_strobe_n && !wq && !i_data_command_select;
    assign kc = ce && i_data[7:0] inside {8'h0D, 8'h0E, 8'h0F};
    assign ok = cq inside {8'h0D, 8'h0E, 8'h0F};
    assign ph = ok && !i_read_strobe_n && i_data_command_select && (i_serial_link || rc != 2'h0);
    // last command and read rises since it; saturates so long reads stay in phase
    always_ff @(posedge i_core_clk)
    begin
        wq <= i_write_strobe_n;
        rq <= i_read_strobe_n;
        rc <= (!i_nrst || ce) ? 2'h0 : rc + 2'((i_read_strobe_n && !rq && rc != 2'h3) ? 1 : 0);
        cq <= !i_nrst ? 8'h00 : (ce ? i_data[7:0] : cq);
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    a_read_taken: assert property (kc |-> ##[1:2] o_read_busy)
        else $error("read command not taken");
    a_refused_idle: assert property (ce && !kc |-> ##2 !o_read_busy)
        else $error("unknown command started a read");
    a_gamma_zero: assert property (ph && cq == 8'h0D |-> o_data[2:0] == IMG_GAMMA_VALUE)
        else $error("gamma bits not zero");
    // the checksum flag reaches the bus two edges after the input
    a_diag_low: assert property (ph && cq == 8'h0F |->
        o_data[5:0] == {5'h00, $past(i_csum_mismatch, 2)})
        else $error("diag low bits wrong");
    // byte offered was assembled from the display state one edge earlier
    a_image_bits: assert property (ph && cq == 8'h0D |->
        o_data[7:3] == {$past(i_scroll_active), 1'b0, $past(i_inversion_on), 2'b00})
        else $error("image mode bits wrong");
    a_signal_bits: assert property (ph && cq == 8'h0E |->
        o_data[7:0] == {$past(i_tearing_on), $past(i_tearing_mode), $past(i_hsync_on),
        $past(i_vsync_on), $past(i_pixel_clock_in_on), $past(i_pixel_data_valid_on),
        1'b0, $past(i_link_error)})
        else $error("signal mode bits wrong");
    a_status_drive: assert property (ph |-> o_data_oe_n == '0)
        else $error("status byte not driven");
    a_idle_release: assert property (i_read_strobe_n |-> &o_data_oe_n)
        else $error("bus driven without read strobe");
    a_byte_holds: assert property (ph && $past(ph) |-> $stable(o_data))
        else $error("status byte changed in a read");
    a_reset_clear: assert property (disable iff (1'b0)
        !i_nrst |=> o_data == '0 && &o_data_oe_n)
        else $error("outputs not cleared by reset");
endmodule : dsr_status_reader_chk
bind dsr_status_reader dsr_status_reader_chk #(.DATA_W(DATA_W)) i_dsr_status_reader_chk (
    .i_core_clk, .i_nrst, .i_data_command_select, .i_read_strobe_n, .i_write_strobe_n,
    .i_data, .o_data, .o_data_oe_n, .i_serial_link, .i_scroll_active, .i_inversion_on,
    .i_tearing_on, .i_tearing_mode, .i_hsync_on, .i_vsync_on, .i_pixel_clock_in_on,
    .i_pixel_data_valid_on, .i_link_error, .i_csum_mismatch, .o_read_busy);

// [dv/test_dsr_status_reader.sv]
// bench: status reads through the host model, diag events, resets
// assumes one core clock; the host model owns the bus strobes
`timescale 1ns/100ps
module test_dsr_status_reader
    import dsr_pkg::*;
();
    logic clk = 1'b0, nrst = 1'b0, ser = 1'b0, cs = 1'b0;
    logic [8:0] st = 9'h000;
    logic [2:0] ev = 3'h0;
    logic dc, rd_n, wr_n, busy;
    logic [7:0] hd, dd, oe, v;
    int num_errors = 0;
    int cmp_count = 0;
    dsr_host_model i_dsr_host_model (.i_core_clk(clk), .i_data(dd), .i_data_oe_n(oe),
        .o_dc(dc), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_data(hd));
    dsr_status_reader i_dsr_status_reader (.i_core_clk(clk), .i_nrst(nrst),
        .i_data_command_select(dc), .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n),
        .i_data(hd), .o_data(dd), .o_data_oe_n(oe), .i_serial_link(ser),
        .i_scroll_active(st[8]), .i_inversion_on(st[7]), .i_tearing_on(st[6]),
        .i_tearing_mode(st[5]), .i_hsync_on(st[4]), .i_vsync_on(st[3]),
        .i_pixel_clock_in_on(st[2]), .i_pixel_data_valid_on(st[1]), .i_link_error(st[0]),
        .i_soft_reset(ev[2]), .i_reg_load_ok(ev[1]), .i_func_check_ok(ev[0]),
        .i_csum_mismatch(cs), .o_read_busy(busy));
    task chk(input logic [7:0] n, input logic [7:0] e, input logic [7:0] s);
        cmp_count++;
        if (s !== e)
        begin
            num_errors++;
            $display("[ERR] cmd %h expected %h seen %h", n, e, s);
        end
    endtask : chk
    // command, dummy read unless serial, then k status reads
    task rs(input logic [7:0] c, input logic [7:0] e, input int k);
        i_dsr_host_model.cmd(c);
        if (!ser)
            i_dsr_host_model.rd(v);
        repeat (k)
        begin
            i_dsr_host_model.rd(v);
            chk(c, e, v);
        end
    endtask : rs
    // one-cycle diag event, then read the diag byte
    task dg(input logic [2:0] p, input logic c, input logic [7:0] e);
        ev <= p;
        cs <= c;
        @(posedge clk);
        ev <= 3'h0;
        rs(CMD_READ_SELF_DIAG, e, 1);
    endtask : dg
    task final_report;
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report
    initial forever #5 clk = ~clk;
    // watchdog: the full sequence needs well under 300 cycles
    initial
    begin
        #20000;
        num_errors++;
        final_report();
    end
    initial
    begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        st <= 9'h180;
        rs(CMD_READ_IMAGE_MODE, 8'hA0, 3);
        st <= 9'h100;
        rs(CMD_READ_IMAGE_MODE, 8'h80, 1);
        st <= 9'h055;
        rs(CMD_READ_SIGNAL_MODE, 8'hA9, 1);
        st <= 9'h02A;
        rs(CMD_READ_SIGNAL_MODE, 8'h54, 2);
        rs(CMD_READ_SELF_DIAG, 8'h00, 1);
        dg(3'h2, 1'b0, 8'h80);
        dg(3'h1, 1'b0, 8'hC0);
        dg(3'h0, 1'b1, 8'hC1);
        dg(3'h2, 1'b1, 8'h41);
        dg(3'h4, 1'b0, 8'h00);
        dg(3'h3, 1'b0, 8'hC0);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rs(CMD_READ_SELF_DIAG, 8'h00, 1);
        i_dsr_host_model.cmd(8'h0C);
        chk(8'h0C, 8'h00, {7'h00, busy});
        ser <= 1'b1;
        st <= 9'h055;
        rs(CMD_READ_SIGNAL_MODE, 8'hA9, 2);
        final_report();
    end
endmodule : test_dsr_status_reader
